// ===== wdt_map.vh
// Register map, field positions, reset values and timing counts of the watchdog
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// I/O port addresses
`define WDT_ADDR_W 16
`define WDT_BES_ADDR 16'h8154
`define TIMEOUT_IRQ_UNMASK_ADDR 16'h8155
`define WDT_MSC_ADDR 16'h815D

// Module status/control fields
`define WDT_MSC_SEL_LO 1
`define WDT_MSC_SEL_HI 2
`define WDT_MSC_TRE 3
`define WDT_MSC_BUS_TIMEOUT_ENABLE 4
// Bits that survive a warm reset (4 and 6)
`define WDT_MSC_WARM_KEEP 8'h50

// Bus event state fields
`define WDT_BES_FLAG 3
// Flag is active low: 1 means no timeout seen
`define WDT_BES_RESET 8'h08
`define WDT_BES_WRITE_MASK 8'hF7

// Event mask fields
`define TIMEOUT_IRQ_UNMASK_UNMASK 3

// Reset values
`define WDT_MSC_RESET 8'h00
`define TIMEOUT_IRQ_UNMASK_RESET 8'h00

// Period select encodings
`define WDT_SEL_OFF 2'h0
`define WDT_SEL_SHORT 2'h1
`define WDT_SEL_MEDIUM 2'h2
`define WDT_SEL_LONG 2'h3

// Timing: clock rate, prescaler tick and periods in ticks
`define WDT_CLK_MHZ 100
`define WDT_TICK_US 1000
`define WDT_TICK_CYCLES (`WDT_TICK_US * `WDT_CLK_MHZ)
`define WDT_SHORT_MS 125
`define WDT_MEDIUM_MS 1000
`define WDT_LONG_MS 8000
`define WDT_TICK_MS (`WDT_TICK_US / 1000)
`define WDT_SHORT_TICKS (`WDT_SHORT_MS / `WDT_TICK_MS)
`define WDT_MEDIUM_TICKS (`WDT_MEDIUM_MS / `WDT_TICK_MS)
`define WDT_LONG_TICKS (`WDT_LONG_MS / `WDT_TICK_MS)
`define WDT_CNT_W 13
`define WDT_PRE_W 24

`endif

// ===== wdt_counter.v
// Prescaler and period counter of the watchdog
`timescale 1ns/1ps
`include "wdt_map.vh"

module wdt_counter #(
  parameter [`WDT_PRE_W-1:0] TICK_CYCLES = `WDT_TICK_CYCLES
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire clear_i,
  input wire run_i,
  input wire [1:0] select_i,
  output reg timeout_o
);

  reg [`WDT_PRE_W-1:0] pre;
  reg [`WDT_CNT_W-1:0] count;
  reg [`WDT_CNT_W-1:0] limit;
  wire tick;

  // Period lengths in prescaler ticks, cut to the counter width
  localparam integer SHORT_N = `WDT_SHORT_TICKS;
  localparam integer MEDIUM_N = `WDT_MEDIUM_TICKS;
  localparam integer LONG_N = `WDT_LONG_TICKS;

  // Terminal count for the selected period
  always @* begin
    case (select_i)
      `WDT_SEL_SHORT: limit = SHORT_N[`WDT_CNT_W-1:0]; // RULE2
      `WDT_SEL_MEDIUM: limit = MEDIUM_N[`WDT_CNT_W-1:0]; // RULE2
      `WDT_SEL_LONG: limit = LONG_N[`WDT_CNT_W-1:0]; // RULE2
      default: limit = {`WDT_CNT_W{1'b1}};
    endcase
  end

  assign tick = run_i && (pre == TICK_CYCLES - 1'b1);

  // Prescaler and binary counter; clear restarts from zero
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre <= {`WDT_PRE_W{1'b0}};
      count <= {`WDT_CNT_W{1'b0}};
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (clear_i) begin
        pre <= {`WDT_PRE_W{1'b0}}; // RULE4
        count <= {`WDT_CNT_W{1'b0}};
      end else if (run_i) begin
        if (tick) begin
          pre <= {`WDT_PRE_W{1'b0}};
          if (count == limit - 1'b1) begin
            count <= {`WDT_CNT_W{1'b0}}; // RULE1
            timeout_o <= 1'b1;
          end else begin
            count <= count + 1'b1;
          end
        end else begin
          pre <= pre + 1'b1;
        end
      end
    end
  end

endmodule

// ===== wdt_top.v
// Watchdog timer with reset and interrupt modes behind I/O registers
//
// Functional notes
// RULE1 - Binary counter overflow signals a timeout
// RULE2 - Periods 125 ms, 1 s or 8 s
// RULE3 - Period chosen by control bits 2 and 1
// RULE4 - Reading status/control restarts the counter
// RULE5 - Reset-enable bit makes timeout force warm reset
// RULE6 - Reset-mode timeout sets the timeout flag
// RULE7 - Watchdog reset clears control bits 1-3
// RULE8 - Reset-mode timeout asserts backplane fail line
// RULE9 - Warm reset keeps control bits 4, 6
// RULE10 - Warm reset clears the reset-enable bit
// RULE11 - Fail line held until flag cleared
// RULE12 - Flag survives warm reset, zero means timeout
// RULE13 - Interrupt mode: masked interrupt, no fail line
// RULE14 - Pending interrupt freezes the counter
// RULE15 - Status/control read services the interrupt
// RULE16 - Interrupt delivered on request line ten
// RULE17 - Interrupt-mode timeout also sets flag low
// RULE18 - Software restarts counter before unmasking
// RULE19 - Soft-reset state suppresses watchdog actions
// RULE20 - Leaving soft reset resumes from cleared count
// RULE21 - Select 00 off, 01/10/11 short/medium/long
// RULE22 - Power-on clears all watchdog state
`timescale 1ns/1ps
`include "wdt_map.vh"

module wdt_top #(
  parameter [`WDT_PRE_W-1:0] TICK_CYCLES = `WDT_TICK_CYCLES
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [`WDT_ADDR_W-1:0] io_addr_i,
  input wire io_rd_i,
  input wire io_wr_i,
  input wire [7:0] io_wdata_i,
  output reg [7:0] io_rdata_o,
  input wire warm_reset_i,
  input wire soft_reset_i,
  output reg warm_reset_o,
  output reg sysfail_drive_o,
  output reg irq10_o,
  output wire [1:0] period_select_o,
  output wire bus_timeout_enable_o
);

  // Address decode shared by reads and writes
  function hit;
    input [`WDT_ADDR_W-1:0] addr;
    input [`WDT_ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  reg [7:0] module_status_control;
  reg [7:0] bus_event_state;
  reg [7:0] event_mask;
  reg irq_pending;

  wire rd_msc;
  wire rd_bes;
  wire rd_mask;
  wire wr_msc;
  wire wr_bes;
  wire wr_mask;
  wire [1:0] period_select;
  wire timeout_reset_enable;
  wire timeout_irq_unmask;
  wire raw_timeout;
  wire timeout;
  wire fire_reset;
  wire fire_irq;
  wire warm_now;
  wire counter_clear;
  wire counter_run;
  reg [7:0] next_rdata;

  // Strobes for the three ports
  assign rd_msc = io_rd_i && hit(io_addr_i, `WDT_MSC_ADDR);
  assign rd_bes = io_rd_i && hit(io_addr_i, `WDT_BES_ADDR);
  assign rd_mask = io_rd_i && hit(io_addr_i, `TIMEOUT_IRQ_UNMASK_ADDR);
  assign wr_msc = io_wr_i && hit(io_addr_i, `WDT_MSC_ADDR);
  assign wr_bes = io_wr_i && hit(io_addr_i, `WDT_BES_ADDR);
  assign wr_mask = io_wr_i && hit(io_addr_i, `TIMEOUT_IRQ_UNMASK_ADDR);

  // Control fields
  assign period_select = {module_status_control[`WDT_MSC_SEL_HI],
                          module_status_control[`WDT_MSC_SEL_LO]}; // RULE3
  assign timeout_reset_enable = module_status_control[`WDT_MSC_TRE];
  assign timeout_irq_unmask = event_mask[`TIMEOUT_IRQ_UNMASK_UNMASK];
  assign period_select_o = period_select;
  assign bus_timeout_enable_o = module_status_control[`WDT_MSC_BUS_TIMEOUT_ENABLE];

  // A warm reset comes from the board or from our own expiry
  assign warm_now = warm_reset_i || warm_reset_o;

  // Counter held cleared on restart, warm reset, soft reset or disable
  assign counter_clear = rd_msc || warm_now || soft_reset_i || // RULE4 RULE20
                         (period_select == `WDT_SEL_OFF); // RULE21
  // Counting clock gated while an interrupt waits for service
  assign counter_run = !irq_pending && !soft_reset_i; // RULE14 RULE19

  wdt_counter #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_counter (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .clear_i(counter_clear),
    .run_i(counter_run),
    .select_i(period_select),
    .timeout_o(raw_timeout)
  );

  // Timeout events split by mode, none during soft reset
  assign timeout = raw_timeout && !soft_reset_i && !warm_now; // RULE19
  assign fire_reset = timeout && timeout_reset_enable; // RULE5
  assign fire_irq = timeout && !timeout_reset_enable; // RULE13

  // Read data mux, unmapped ports read as zero
  always @* begin
    next_rdata = 8'h00;
    if (rd_msc) begin
      next_rdata = module_status_control;
    end else if (rd_bes) begin
      next_rdata = bus_event_state;
    end else if (rd_mask) begin
      next_rdata = event_mask;
    end
  end

  // Read data register
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_rdata_o <= 8'h00;
    end else begin
      io_rdata_o <= next_rdata;
    end
  end

  // Warm reset request, one cycle per expiry
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      warm_reset_o <= 1'b0;
    end else begin
      warm_reset_o <= fire_reset; // RULE5
    end
  end

  // Status/control register
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      module_status_control <= `WDT_MSC_RESET; // RULE22
    end else if (warm_now) begin
      // Only bits 4 and 6 survive; reset-enable dropped
      module_status_control <= module_status_control &
                               `WDT_MSC_WARM_KEEP; // RULE9 RULE10
    end else if (fire_reset) begin
      // Disarm at once so the warm reset cannot expire again
      module_status_control[`WDT_MSC_SEL_LO] <= 1'b0; // RULE7
      module_status_control[`WDT_MSC_SEL_HI] <= 1'b0;
      module_status_control[`WDT_MSC_TRE] <= 1'b0;
    end else if (wr_msc) begin
      module_status_control <= io_wdata_i;
    end
  end

  // Event mask register
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_mask <= `TIMEOUT_IRQ_UNMASK_RESET; // RULE22
    end else if (warm_now) begin
      event_mask <= `TIMEOUT_IRQ_UNMASK_RESET; // RULE9
    end else if (wr_mask) begin
      event_mask <= io_wdata_i;
    end
  end

  // Bus event state; timeout flag is active low and sticky
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_event_state <= `WDT_BES_RESET; // RULE22
    end else begin
      if (warm_now) begin
        // Flag alone survives a warm reset
        bus_event_state <= bus_event_state & ~`WDT_BES_WRITE_MASK; // RULE12
      end else if (wr_bes) begin
        bus_event_state <= (io_wdata_i & `WDT_BES_WRITE_MASK) |
                           (bus_event_state & ~`WDT_BES_WRITE_MASK);
      end
      // Timeout drives flag to 0 and wins over a same-cycle read
      if (timeout) begin
        bus_event_state[`WDT_BES_FLAG] <= 1'b0; // RULE6 RULE17
      end else if (rd_msc) begin
        bus_event_state[`WDT_BES_FLAG] <= 1'b1; // RULE11
      end
    end
  end

  // Backplane fail line, held through warm reset until flag clears
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sysfail_drive_o <= 1'b0; // RULE22
    end else if (fire_reset) begin
      sysfail_drive_o <= 1'b1; // RULE8
    end else if (rd_msc) begin
      sysfail_drive_o <= 1'b0; // RULE11
    end
  end

  // Interrupt pending; set wins over a same-cycle service read
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_pending <= 1'b0;
    end else if (fire_irq && timeout_irq_unmask) begin
      irq_pending <= 1'b1; // RULE13
    end else if (rd_msc || warm_now || soft_reset_i) begin
      irq_pending <= 1'b0; // RULE15 RULE19
    end
  end

  // Interrupt request line ten, only while unmasked
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq10_o <= 1'b0;
    end else begin
      irq10_o <= (fire_irq && timeout_irq_unmask) ||
                 (irq_pending && timeout_irq_unmask &&
                  !rd_msc && !warm_now && !soft_reset_i); // RULE16
    end
  end

endmodule

// ===== wdt_board.sv
// Board reset sequencer and backplane fail line around the watchdog
`timescale 1ns/1ps
module wdt_board (
  input wire mclk_i,
  input wire warm_req_i,
  input wire sysfail_drive_i,
  output reg warm_reset_o,
  output wire sysfail_n_o
);
  reg [1:0] hold = 2'h0;
  // Stretch a one-cycle request into a three-cycle warm reset
  always @(posedge mclk_i) begin
    if (warm_req_i)
      hold <= 2'h3;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
  end
  always @* warm_reset_o = (hold != 2'h0);
  // Wired line with pull-up, pulled low while driven
  assign sysfail_n_o = sysfail_drive_i ? 1'b0 : 1'b1;
endmodule

// ===== wdt_top_chk.sv
// Assertion checker on the watchdog top-level ports
`timescale 1ns/1ps
module wdt_top_chk #(
  parameter [23:0] TICK_CYCLES = 24'h4
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [15:0] io_addr_i,
  input wire io_rd_i,
  input wire io_wr_i,
  input wire [7:0] io_wdata_i,
  input wire [7:0] io_rdata_o,
  input wire warm_reset_i,
  input wire soft_reset_i,
  input wire warm_reset_o,
  input wire sysfail_drive_o,
  input wire irq10_o,
  input wire [1:0] period_select_o,
  input wire bus_timeout_enable_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Read of the status/control register
  wire rd_ctl = io_rd_i && io_addr_i == 16'h815D;
  chk_reset_pulse: assert property (warm_reset_o |=> !warm_reset_o)
    else $error("warm reset pulse too long");
  chk_fail_with_reset: assert property (
    $rose(warm_reset_o) |-> sysfail_drive_o)
    else $error("no fail line with watchdog reset");
  chk_select_cleared: assert property (
    $rose(warm_reset_o) |-> period_select_o == 2'h0)
    else $error("select kept after watchdog reset");
  chk_fail_holds: assert property (
    sysfail_drive_o && !rd_ctl |=> sysfail_drive_o)
    else $error("fail line dropped early");
  chk_read_release: assert property (
    rd_ctl && period_select_o == 2'h0 |=> !sysfail_drive_o && !irq10_o)
    else $error("read did not release");
  chk_soft_quiet: assert property (
    soft_reset_i ##1 soft_reset_i |=> !irq10_o && !warm_reset_o)
    else $error("action during soft reset");
  chk_warm_clears: assert property (
    warm_reset_i |=> period_select_o == 2'h0 && !irq10_o)
    else $error("warm reset left state");
  chk_keep_bit4: assert property (
    warm_reset_i |=> $stable(bus_timeout_enable_o))
    else $error("bit 4 lost in warm reset");
  chk_irq_no_fail: assert property (
    $rose(irq10_o) |-> !$rose(sysfail_drive_o))
    else $error("fail line in interrupt mode");
  chk_soft_restart: assert property (
    $fell(soft_reset_i) |-> (!irq10_o && !warm_reset_o) [*8])
    else $error("early event after soft reset");
  cover property ($rose(warm_reset_o));
  cover property ($rose(irq10_o));
  cover property ($fell(sysfail_drive_o));
endmodule
bind wdt_top wdt_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);

// ===== watchdog_timer_reset_irq_test.sv
// Register-level testbench of the watchdog
`timescale 1ns/1ps
module watchdog_timer_reset_irq_test;
  reg mclk_i = 0, reset_n_i = 0, io_rd_i = 0, io_wr_i = 0, soft_reset_i = 0;
  reg [15:0] io_addr_i = 16'h0000;
  reg [7:0] io_wdata_i = 8'h00;
  wire [7:0] io_rdata_o;
  wire [1:0] period_select_o;
  wire warm_reset_i, warm_reset_o, sysfail_drive_o, irq10_o, sysfail_n;
  wire bus_timeout_enable_o;
  int failures = 0, n_compared = 0, n, i;
  int per[3] = '{125 * 4, 1000 * 4, 8000 * 4};
  wdt_top #(.TICK_CYCLES(24'h4)) dut (.*);
  wdt_board brd (.mclk_i(mclk_i), .warm_req_i(warm_reset_o),
    .sysfail_drive_i(sysfail_drive_o), .warm_reset_o(warm_reset_i),
    .sysfail_n_o(sysfail_n));
  initial forever #5 mclk_i = ~mclk_i;
  task end_sim;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input [7:0] seen, input [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle; read data is valid after the next edge
  task acc(input w, input [15:0] a, input [7:0] d);
    @(posedge mclk_i) #1;
    io_addr_i = a;
    io_wdata_i = d;
    io_rd_i = !w;
    io_wr_i = w;
    @(posedge mclk_i) #1;
    io_rd_i = 0;
    io_wr_i = 0;
  endtask
  task rd(input [15:0] a, input [7:0] exp);
    acc(0, a, 8'h00);
    check(io_rdata_o, exp);
  endtask
  // Bounded wait for warm reset (1) or interrupt (0)
  task wait_for(input sel);
    n = 0;
    while ((sel ? warm_reset_o : irq10_o) !== 1'b1) begin
      @(posedge mclk_i) #1;
      n++;
      if (n > 40000) begin
        failures++;
        $display("unexpected at %0t: no event", $time);
        end_sim;
      end
    end
  endtask
  task near(input int e);
    check({7'h00, n > e - 10 && n < e + 10}, 8'h01);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    #1 reset_n_i = 1;
    rd(16'h8154, 8'h08);
    rd(16'h8155, 8'h00);
    rd(16'h815D, 8'h00);
    rd(16'h8156, 8'h00);
    $display("test reset values done");
    acc(1, 16'h815D, 8'h5A);
    wait_for(1);
    near(per[0]);
    check({7'h00, sysfail_n}, 8'h00);
    repeat (6) @(posedge mclk_i);
    rd(16'h8154, 8'h00);
    check({7'h00, sysfail_drive_o}, 8'h01);
    check({6'h00, period_select_o}, 8'h00);
    check({7'h00, bus_timeout_enable_o}, 8'h01);
    rd(16'h815D, 8'h50);
    check({7'h00, sysfail_drive_o}, 8'h00);
    rd(16'h8154, 8'h08);
    $display("test reset mode done");
    acc(1, 16'h815D, 8'h0A);
    repeat (4) begin
      repeat (400) @(posedge mclk_i);
      rd(16'h815D, 8'h0A);
    end
    acc(1, 16'h815D, 8'h00);
    $display("test restart done");
    rd(16'h815D, 8'h00);
    acc(1, 16'h8155, 8'h08);
    for (i = 1; i < 4; i++) begin
      acc(1, 16'h815D, {5'h00, i[1:0], 1'b0});
      wait_for(0);
      near(per[i - 1]);
      check({7'h00, sysfail_n}, 8'h01);
      rd(16'h8154, 8'h00);
      repeat (600) @(posedge mclk_i);
      #1 check({7'h00, irq10_o}, 8'h01);
      rd(16'h815D, {5'h00, i[1:0], 1'b0});
      check({7'h00, irq10_o}, 8'h00);
    end
    $display("test interrupt mode done");
    acc(1, 16'h815D, 8'h02);
    repeat (300) @(posedge mclk_i);
    #1 soft_reset_i = 1;
    repeat (800) @(posedge mclk_i);
    #1 check({7'h00, irq10_o}, 8'h00);
    soft_reset_i = 0;
    wait_for(0);
    near(per[0]);
    $display("test soft reset done");
    rd(16'h815D, 8'h02);
    check({7'h00, irq10_o}, 8'h00);
    acc(1, 16'h8155, 8'h00);
    repeat (520) @(posedge mclk_i);
    #1 check({7'h00, irq10_o}, 8'h00);
    rd(16'h8154, 8'h00);
    $display("test masked timeout done");
    end_sim;
  end
endmodule
